// File: flash_seq_pkg.sv
/*
  Shared constants and carrier types for the flash command sequencer.
  Assumes a 32-bit APB register bus and a single 125 MHz clock domain.
*/
package flash_seq_pkg;

  // ----------------------------------------------------------------
  // Register map (word indices, one aligned word each)
  // ----------------------------------------------------------------
  // Printed offsets are not all multiples of four, so they are indices
  localparam logic [19:0] IDX_CTRL0   = 20'h00220;
  localparam logic [19:0] IDX_CTRL1   = 20'h00221;
  localparam logic [19:0] IDX_CTRL2   = 20'h00222;
  localparam logic [19:0] IDX_CTRL3   = 20'h00223;
  localparam logic [19:0] IDX_CTRL6   = 20'h00230;
  localparam logic [19:0] IDX_OPTSEL  = 20'hFFFFF;
  // Command port, suspend control and status
  localparam logic [19:0] IDX_CMD     = 20'h00240;
  localparam logic [19:0] IDX_SUSP    = 20'h00241;
  localparam logic [19:0] IDX_STAT    = 20'h00242;
  // Target address for the next command write
  localparam logic [19:0] IDX_CADDR   = 20'h00243;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL0_LOCK_DIS  = 2;
  localparam int CTRL1_C6_WEN    = 1;
  localparam int CTRL1_LOCK_STAT = 6;
  localparam int CTRL1_DF_WAIT   = 7;
  localparam int SUSP_REQ        = 0;
  localparam int STAT_BLANK      = 0;
  localparam int STAT_BUSY       = 1;
  localparam int STAT_REFUSED    = 2;
  localparam int STAT_SEQ_ERR    = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL0_RST  = 8'h00;
  localparam logic [7:0] CTRL1_RST  = 8'h00;
  localparam logic [7:0] CTRLX_RST  = 8'h00;
  localparam logic [7:0] OPTSEL_VAL = 8'hFF;

  // ----------------------------------------------------------------
  // Command codes (low byte only)
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_PROGRAM = 8'h41;
  localparam logic [7:0] CMD_LOCKPRG = 8'h77;
  localparam logic [7:0] CMD_LOCKRD  = 8'h71;
  localparam logic [7:0] CMD_BLANK   = 8'h25;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;

  // ----------------------------------------------------------------
  // Array geometry and timing
  // ----------------------------------------------------------------
  localparam int ADDR_W          = 20;
  localparam int BLK_SHIFT       = 12;
  localparam int NUM_BLOCKS      = 16;
  localparam int PROG_TIME_US    = 50;
  localparam int CLK_MHZ         = 125;
  localparam int PROG_CYCLES     = PROG_TIME_US * CLK_MHZ;
  localparam int PROG_CNT_W      = 16;

  // Sequencer states, Gray along the program path
  typedef enum logic [2:0] {
    ST_READ  = 3'b000,
    ST_LOW   = 3'b001,
    ST_HIGH  = 3'b011,
    ST_BUSY  = 3'b010,
    ST_CONF  = 3'b110,
    ST_SUSP  = 3'b111
  } seq_state_t;

  // One command bus write
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [15:0]       data;
  } cmd_write_t;

  // Request toward the flash array
  typedef struct packed {
    logic              prog;
    logic              lock_set;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       data;
  } array_req_t;

endpackage

// File: flash_lock_bits.sv
/*
  Per-block lock bit store for the flash sequencer.
  Assumes block index decoded by the caller; all on one clock.
*/
module flash_lock_bits #(
  parameter int NUM_BLOCKS = 16
) (
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic                          set_en,
  input  wire logic [$clog2(NUM_BLOCKS)-1:0] idx,
  output      logic                          locked
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [NUM_BLOCKS-1:0] lock_q; // One set bit means block locked

  // Each entry sets only; erased state is unlocked
  generate
    for (genvar i = 0; i < NUM_BLOCKS; i++) begin : g_lock
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          lock_q[i] <= 1'b0;
        end else if (set_en && idx == i) begin
          lock_q[i] <= 1'b1;
        end
      end
    end
  endgenerate

  // Selected block's lock state
  assign locked = lock_q[idx];

endmodule

// File: flash_command_sequencer.sv
/*
  Flash command sequencer: APB slave holding the flash control
  registers and a command port that decodes multi-cycle commands.
  Assumes one 125 MHz clock, asynchronous active-high reset and an
  external array that accepts one-cycle program requests.
*/
module flash_command_sequencer #(
  parameter int PROG_CYCLES = flash_seq_pkg::PROG_CYCLES
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [21:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output      logic [31:0] PRDATA,
  output      logic        PREADY,
  output      logic        PSLVERR,
  // Flash array side
  output      logic        ARRAY_PROG,
  output      logic [19:0] ARRAY_ADDR,
  output      logic [31:0] ARRAY_DATA,
  output      logic        DATA_FLASH_ONE_WAIT,
  output      logic        BUSY
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic        acc;      // Access phase of a transfer
  logic        wr;       // Write taking effect this edge
  logic [19:0] idx;      // Register index from byte address
  assign acc    = PSEL && PENABLE;
  assign wr     = acc && PWRITE;
  assign idx    = PADDR[21:2];
  assign PREADY = 1'b1;  // Zero-wait slave

  logic hit_c0, hit_c1, hit_c2, hit_c3, hit_c6, hit_opt, hit_cmd;
  logic hit_susp, hit_stat, hit_caddr, mapped;
  assign hit_c0   = idx == flash_seq_pkg::IDX_CTRL0;
  assign hit_c1   = idx == flash_seq_pkg::IDX_CTRL1;
  assign hit_c2   = idx == flash_seq_pkg::IDX_CTRL2;
  assign hit_c3   = idx == flash_seq_pkg::IDX_CTRL3;
  assign hit_c6   = idx == flash_seq_pkg::IDX_CTRL6;
  assign hit_opt  = idx == flash_seq_pkg::IDX_OPTSEL;
  assign hit_cmd  = idx == flash_seq_pkg::IDX_CMD;
  assign hit_susp = idx == flash_seq_pkg::IDX_SUSP;
  assign hit_stat = idx == flash_seq_pkg::IDX_STAT;
  assign hit_caddr = idx == flash_seq_pkg::IDX_CADDR;
  assign mapped   = hit_c0 | hit_c1 | hit_c2 | hit_c3 | hit_c6 | hit_opt
                  | hit_cmd | hit_susp | hit_stat | hit_caddr;
  // Unmapped addresses answer with an error, read data zero
  assign PSLVERR  = acc && !mapped;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl0_q;   // Control 0
  logic [7:0] ctrl1_q;   // Control 1 (bit 6 is hardware status)
  logic [7:0] ctrl2_q;   // Control 2, plain storage
  logic [7:0] ctrl3_q;   // Control 3, plain storage
  logic [7:0] ctrl6_q;   // Control 6, write gated
  logic       susp_q;    // Suspend request
  logic       lock_stat_q; // Result of last lock status read
  logic       lock_stat_set;
  logic       lock_stat_val;
  logic       c6_wen;

  assign c6_wen = ctrl1_q[flash_seq_pkg::CTRL1_C6_WEN];

  // Software writes to control registers
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ctrl0_q <= flash_seq_pkg::CTRL0_RST;
      ctrl1_q <= flash_seq_pkg::CTRL1_RST;
      ctrl2_q <= flash_seq_pkg::CTRLX_RST;
      ctrl3_q <= flash_seq_pkg::CTRLX_RST;
      ctrl6_q <= flash_seq_pkg::CTRLX_RST;
      susp_q  <= 1'b0;
    end else if (wr) begin
      if (hit_c0) ctrl0_q <= PWDATA[7:0];
      if (hit_c1) ctrl1_q <= PWDATA[7:0];
      if (hit_c2) ctrl2_q <= PWDATA[7:0];
      if (hit_c3) ctrl3_q <= PWDATA[7:0];
      // writes dropped while gate is closed
      if (hit_c6 && c6_wen) ctrl6_q <= PWDATA[7:0];
      if (hit_susp) susp_q <= PWDATA[flash_seq_pkg::SUSP_REQ];
    end
  end

  // status flag updated by lock status reads only
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      lock_stat_q <= 1'b1;
    end else if (lock_stat_set) begin
      lock_stat_q <= lock_stat_val;
    end
  end

  // wait select, 0 gives one wait state
  assign DATA_FLASH_ONE_WAIT = !ctrl1_q[flash_seq_pkg::CTRL1_DF_WAIT];

  // ----------------------------------------------------------------
  // Command address checks
  // ----------------------------------------------------------------
  localparam int BW = $clog2(flash_seq_pkg::NUM_BLOCKS); // Block index width
  localparam int CW = flash_seq_pkg::PROG_CNT_W;          // Busy counter width
  localparam int BS = flash_seq_pkg::BLK_SHIFT;           // Block size, log2
  localparam logic [CW-1:0] PROG_LOAD = CW'(PROG_CYCLES - 1);
  // Whole block array taken as one region; program ROM and data flash
  // are not told apart, a limitation if their ranges ever leave gaps
  localparam logic [19:0] FLASH_END = 20'(flash_seq_pkg::NUM_BLOCKS << BS);

  flash_seq_pkg::cmd_write_t cmd_in;   // Command write on the bus now
  logic [19:0]   caddr_q;              // Software-set command address
  logic          cmd_wr;               // Command write taking effect
  logic [7:0]    cmd_code;             // Decoded command byte
  logic          in_flash;             // Address inside the array
  logic          even_ok;              // Even address
  logic          dword_ok;             // Double word aligned address
  logic          blk_top;              // Highest even address of a block
  logic [BW-1:0] cmd_blk;              // Block of the command address

  // Command address register
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      caddr_q <= 20'h00000;
    end else if (wr && hit_caddr) begin
      caddr_q <= PWDATA[19:0];
    end
  end

  assign cmd_wr      = wr && hit_cmd;
  assign cmd_in.addr = caddr_q;
  assign cmd_in.data = PWDATA[15:0];
  assign cmd_code    = cmd_in.data[7:0];
  // any address inside the array, even or odd
  assign in_flash    = cmd_in.addr < FLASH_END;
  assign even_ok     = !cmd_in.addr[0];
  // only 0, 4, 8 or C accepted
  assign dword_ok    = cmd_in.addr[1:0] == 2'h0;
  // block address is the top even word
  assign blk_top     = (&cmd_in.addr[BS-1:1]) && even_ok;
  assign cmd_blk     = cmd_in.addr[BS +: BW];

  // ----------------------------------------------------------------
  // Sequencer decisions
  // ----------------------------------------------------------------
  flash_seq_pkg::seq_state_t  state_q;    // Sequencer state
  flash_seq_pkg::seq_state_t  state_d;    // Next state
  flash_seq_pkg::cmd_write_t  tgt_q;      // Program target and low half
  flash_seq_pkg::array_req_t  req_q;      // Request toward the array
  logic [7:0]    op_q;                    // Command awaiting confirm
  logic [CW-1:0] busy_cnt_q;              // Remaining program cycles
  logic [BW-1:0] tgt_blk;                 // Block of the program target
  logic [BW-1:0] lk_idx;                  // Block whose lock is looked up
  logic          lk_locked;               // That block's lock bit
  logic          lock_set;                // Lock bit program confirmed
  logic          lock_block;              // Lock protection refuses
  logic          same_tgt;                // Write goes to the same target
  logic          cmd_live;                // Sequencer takes commands
  logic          prog_start, conf_start, low_take, high_take;
  logic          prog_go, conf_take, blank_done, bad_seq;
  logic [flash_seq_pkg::NUM_BLOCKS-1:0] used_q; // Programmed since reset
  logic          blank_q;                 // Last blank check result
  logic          refused_q;               // Last program refused by lock
  logic          seq_err_q;               // Last command write abandoned

  assign tgt_blk  = tgt_q.addr[BS +: BW];
  assign same_tgt = cmd_in.addr == tgt_q.addr;
  assign cmd_live = state_q != flash_seq_pkg::ST_BUSY
                 && state_q != flash_seq_pkg::ST_SUSP;
  // Confirm looks up the block written to, program its own target
  assign lk_idx   = (state_q == flash_seq_pkg::ST_CONF) ? cmd_blk : tgt_blk;

  // program opens with 41h at an aligned target
  assign prog_start = cmd_wr && state_q == flash_seq_pkg::ST_READ
                   && cmd_code == flash_seq_pkg::CMD_PROGRAM && in_flash && dword_ok;
  // 77h to a block address; 71h or 25h anywhere even
  assign conf_start = cmd_wr && state_q == flash_seq_pkg::ST_READ && in_flash
                   && ((cmd_code == flash_seq_pkg::CMD_LOCKPRG && blk_top)
                    || ((cmd_code == flash_seq_pkg::CMD_LOCKRD
                      || cmd_code == flash_seq_pkg::CMD_BLANK) && even_ok));
  // second cycle carries the low half
  assign low_take   = cmd_wr && state_q == flash_seq_pkg::ST_LOW && same_tgt;
  // third cycle carries the high half
  assign high_take  = cmd_wr && state_q == flash_seq_pkg::ST_HIGH && same_tgt;
  // locked block refused; unless lock bits disabled
  assign lock_block = lk_locked && !ctrl0_q[flash_seq_pkg::CTRL0_LOCK_DIS];
  assign prog_go    = high_take && !lock_block;
  // confirm D0h at the block address
  assign conf_take  = cmd_wr && state_q == flash_seq_pkg::ST_CONF
                   && cmd_code == flash_seq_pkg::CMD_CONFIRM && in_flash && blk_top;
  assign lock_set   = conf_take && op_q == flash_seq_pkg::CMD_LOCKPRG;
  assign blank_done = conf_take && op_q == flash_seq_pkg::CMD_BLANK;
  // lock status flag 0 means locked
  assign lock_stat_set = conf_take && op_q == flash_seq_pkg::CMD_LOCKRD;
  assign lock_stat_val = !lk_locked;
  assign bad_seq    = cmd_wr && cmd_live
                   && !(prog_start || conf_start || low_take || high_take || conf_take);

  // Per-block lock store
  flash_lock_bits #(
    .NUM_BLOCKS (flash_seq_pkg::NUM_BLOCKS)
  ) u_flash_lock_bits (
    .clk    (CLK),
    .reset  (RESET),
    .set_en (lock_set),
    .idx    (lk_idx),
    .locked (lk_locked)
  );

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  // Next state; a stray write in any command state falls back to read
  always_comb begin
    state_d = state_q;
    case (state_q)
      flash_seq_pkg::ST_READ: begin
        if (prog_start) begin
          state_d = flash_seq_pkg::ST_LOW;
        end else if (conf_start) begin
          state_d = flash_seq_pkg::ST_CONF;
        end
      end
      flash_seq_pkg::ST_LOW: begin
        if (cmd_wr) begin
          state_d = low_take ? flash_seq_pkg::ST_HIGH : flash_seq_pkg::ST_READ;
        end
      end
      flash_seq_pkg::ST_HIGH: begin
        if (cmd_wr) begin
          state_d = prog_go ? flash_seq_pkg::ST_BUSY : flash_seq_pkg::ST_READ;
        end
      end
      // suspend holds the program, release resumes it
      flash_seq_pkg::ST_BUSY: begin
        if (susp_q) begin
          state_d = flash_seq_pkg::ST_SUSP;
        end else if (busy_cnt_q == '0) begin
          state_d = flash_seq_pkg::ST_READ;
        end
      end
      flash_seq_pkg::ST_SUSP: begin
        if (!susp_q) begin
          state_d = flash_seq_pkg::ST_BUSY;
        end
      end
      flash_seq_pkg::ST_CONF: begin
        if (cmd_wr) begin
          state_d = flash_seq_pkg::ST_READ;
        end
      end
      default: begin
        state_d = flash_seq_pkg::ST_READ;
      end
    endcase
  end

  // State and busy counter; the count freezes while suspended
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_q    <= flash_seq_pkg::ST_READ;
      busy_cnt_q <= '0;
    end else begin
      state_q <= state_d;
      if (prog_go) begin
        busy_cnt_q <= PROG_LOAD;
      end else if (state_q == flash_seq_pkg::ST_BUSY && !susp_q && busy_cnt_q != '0) begin
        busy_cnt_q <= busy_cnt_q - 1'b1;
      end
    end
  end

  // Target and pending command latches
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      tgt_q <= '0;
      op_q  <= 8'h00;
    end else begin
      if (prog_start) tgt_q.addr <= cmd_in.addr;
      if (low_take)   tgt_q.data <= cmd_in.data;
      if (conf_start) op_q       <= cmd_code;
    end
  end

  // one 32-bit request per completed program
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      req_q <= '0;
    end else begin
      req_q.prog     <= prog_go;
      req_q.lock_set <= lock_set;
      if (prog_go) begin
        req_q.addr <= tgt_q.addr;
        req_q.data <= {cmd_in.data, tgt_q.data};
      end
    end
  end

  assign ARRAY_PROG = req_q.prog;
  assign ARRAY_ADDR = req_q.addr;
  assign ARRAY_DATA = req_q.data;
  assign BUSY       = !cmd_live;

  // Blocks written since reset, for the blank check
  generate
    for (genvar b = 0; b < flash_seq_pkg::NUM_BLOCKS; b++) begin : g_used
      always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
          used_q[b] <= 1'b0;
        end else if (prog_go && tgt_blk == b) begin
          used_q[b] <= 1'b1;
        end
      end
    end
  endgenerate

  // Result flags keep the latest blank check, program and command write
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      blank_q   <= 1'b0;
      refused_q <= 1'b0;
      seq_err_q <= 1'b0;
    end else begin
      if (blank_done) blank_q   <= !used_q[cmd_blk];
      if (high_take)  refused_q <= lock_block;
      if (cmd_wr)     seq_err_q <= bad_seq;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0]  ctrl1_rd;  // Control 1 with hardware status merged
  logic [7:0]  stat_rd;   // Sequencer status
  logic [31:0] rd_mux;    // Selected register
  logic [31:0] prdata_q;  // Read data held through the access phase

  // Status bits overlay stored bits
  always_comb begin
    ctrl1_rd = ctrl1_q;
    ctrl1_rd[flash_seq_pkg::CTRL1_LOCK_STAT] = lock_stat_q;
    stat_rd = 8'h00;
    stat_rd[flash_seq_pkg::STAT_BLANK]   = blank_q;
    stat_rd[flash_seq_pkg::STAT_BUSY]    = BUSY;
    stat_rd[flash_seq_pkg::STAT_REFUSED] = refused_q;
    stat_rd[flash_seq_pkg::STAT_SEQ_ERR] = seq_err_q;
  end

  assign rd_mux = hit_c0    ? {24'h000000, ctrl0_q}
                : hit_c1    ? {24'h000000, ctrl1_rd}
                : hit_c2    ? {24'h000000, ctrl2_q}
                : hit_c3    ? {24'h000000, ctrl3_q}
                : hit_c6    ? {24'h000000, ctrl6_q}
                : hit_opt   ? {24'h000000, flash_seq_pkg::OPTSEL_VAL}
                : hit_susp  ? {31'h00000000, susp_q}
                : hit_stat  ? {24'h000000, stat_rd}
                : hit_caddr ? {12'h000, caddr_q}
                : 32'h00000000;

  // Captured in the setup cycle so the zero-wait access sees a flop
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      prdata_q <= 32'h00000000;
    end else if (PSEL && !PENABLE) begin
      prdata_q <= rd_mux;
    end
  end

  assign PRDATA = prdata_q;

endmodule

// File: flash_seq_monitor.sv
/*
  Concurrent checks on the sequencer's top-level ports.
  Assumes one clock, reset asynchronous and active high.
*/
module flash_seq_monitor (
  input wire logic        CLK,
  input wire logic        RESET,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [21:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        ARRAY_PROG,
  input wire logic [19:0] ARRAY_ADDR,
  input wire logic [31:0] ARRAY_DATA,
  input wire logic        DATA_FLASH_ONE_WAIT,
  input wire logic        BUSY
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  // Completed write to control register 1
  wire c1_wr = PSEL && PENABLE && PREADY && PWRITE
               && PADDR == {flash_seq_pkg::IDX_CTRL1, 2'b00};
  wire opt_rd = PSEL && PENABLE && PREADY && !PWRITE
                && PADDR == {flash_seq_pkg::IDX_OPTSEL, 2'b00};
  a_prog_aligned: assert property (ARRAY_PROG |-> ARRAY_ADDR[1:0] == 2'h0)
    else $error("program address not word aligned");
  a_prog_pulse: assert property (ARRAY_PROG |=> !ARRAY_PROG)
    else $error("program request longer than one cycle");
  a_wait_select: assert property (c1_wr |=> DATA_FLASH_ONE_WAIT == !$past(PWDATA[7]))
    else $error("data flash wait output wrong after write");
  a_wait_hold: assert property (!c1_wr |=> $stable(DATA_FLASH_ONE_WAIT))
    else $error("data flash wait changed without a write");
  a_wait_reset: assert property ($past(RESET) |-> DATA_FLASH_ONE_WAIT)
    else $error("data flash wait not one wait after reset");
  a_ready_bound: assert property (PSEL && PENABLE |-> ##[0:16] PREADY)
    else $error("bus access not answered");
  a_err_timing: assert property (PSLVERR |-> PSEL && PENABLE && PREADY)
    else $error("error response outside access phase");
  a_option_value: assert property (opt_rd |-> PRDATA[7:0] == flash_seq_pkg::OPTSEL_VAL)
    else $error("option select read wrong");
  a_prog_busy: assert property (ARRAY_PROG |-> BUSY)
    else $error("program request without busy");
  a_err_zero: assert property (PSLVERR |-> PRDATA == 32'h00000000)
    else $error("error response with read data");
endmodule

bind flash_command_sequencer flash_seq_monitor u_flash_seq_monitor (.*);

// File: flash_array_model.sv
/*
  Flash array stand-in: records one-cycle program requests.
  Assumes requests come from the sequencer on the shared clock.
*/
module flash_array_model (
  input wire logic        clk,
  input wire logic        prog,
  input wire logic [19:0] addr,
  input wire logic [31:0] data
);
  timeunit 1ns;
  timeprecision 1ps;
  int          prog_count_q = 0; // Programs seen
  logic [31:0] last_data_q;      // Last stored double word
  always @(posedge clk) if (prog) begin
    prog_count_q <= prog_count_q + 1;
    last_data_q  <= data;
  end
endmodule

// File: tb_top.sv
/*
  Self-checking bench: APB register scenarios for the sequencer.
  Assumes a 125 MHz clock and a two-cycle reset at start.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [21:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        err;
  logic        pready, pslverr, aprog, one_wait, busy;
  logic [19:0] aaddr;
  logic [31:0] adata;
  int          fails = 0, samples_checked = 0, cycles = 0;
  flash_command_sequencer #(.PROG_CYCLES(20)) u_flash_command_sequencer (
    .CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .ARRAY_PROG(aprog), .ARRAY_ADDR(aaddr), .ARRAY_DATA(adata),
    .DATA_FLASH_ONE_WAIT(one_wait), .BUSY(busy));
  flash_array_model u_flash_array_model (.clk(clk), .prog(aprog), .addr(aaddr), .data(adata));
  initial forever #4 clk = ~clk;
  // Hang guard
  always @(posedge clk) if (++cycles == 20000) begin
    fails++;
    report_and_stop();
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer, held until ready
  task automatic apb(input logic w, input logic [19:0] idx, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= {idx, 2'b00}; pwdata <= wd; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // One command write: target address, then command word
  task automatic cmd(input logic [19:0] a, input logic [31:0] d);
    apb(1, flash_seq_pkg::IDX_CADDR, {12'h000, a});
    apb(1, flash_seq_pkg::IDX_CMD, d);
  endtask
  // Three-cycle program, upper command byte set to prove it is ignored
  task automatic prog(input logic [19:0] a, input logic [31:0] d);
    cmd(a, 32'h0000FF41);
    cmd(a, {16'h0000, d[15:0]});
    cmd(a, {16'h0000, d[31:16]});
  endtask
  task automatic stat_bit(input string what, input int b, input logic exp);
    apb(0, flash_seq_pkg::IDX_STAT, 0);
    check(what, {31'h0, exp}, {31'h0, rd[b]});
  endtask
  task automatic lock_read(input logic [19:0] ba, input logic exp);
    cmd(20'h00000, 32'h00000071);
    cmd(ba, 32'h000000D0);
    apb(0, flash_seq_pkg::IDX_CTRL1, 0);
    check("lock status", {31'h0, exp}, {31'h0, rd[6]});
  endtask
  task automatic program_word();
    prog(20'h01004, 32'h12345678);
    @(posedge clk);
    check("busy on", 32'h1, {31'h0, busy});
    check("array addr", 32'h01004, {12'h0, aaddr});
    repeat (25) @(posedge clk);
    check("busy off", 32'h0, {31'h0, busy});
    check("prog count", 32'd1, u_flash_array_model.prog_count_q);
    check("prog data", 32'h12345678, u_flash_array_model.last_data_q);
  endtask
  task automatic lock_scenario();
    apb(1, flash_seq_pkg::IDX_CTRL0, 32'h00);
    lock_read(20'h01FFE, 1'b1);
    cmd(20'h01FFE, 32'h00000077);
    cmd(20'h01FFE, 32'h000000D0);
    lock_read(20'h01FFE, 1'b0);
    prog(20'h01008, 32'hCAFE0001);
    repeat (25) @(posedge clk);
    check("refused count", 32'd1, u_flash_array_model.prog_count_q);
    stat_bit("refused flag", flash_seq_pkg::STAT_REFUSED, 1'b1);
    apb(1, flash_seq_pkg::IDX_CTRL0, 32'h04);
    prog(20'h01008, 32'hCAFE0002);
    repeat (25) @(posedge clk);
    check("disabled count", 32'd2, u_flash_array_model.prog_count_q);
    check("disabled data", 32'hCAFE0002, u_flash_array_model.last_data_q);
  endtask
  task automatic blank_and_bad();
    cmd(20'h00000, 32'h00000025);
    cmd(20'h02FFE, 32'h000000D0);
    stat_bit("blank empty", flash_seq_pkg::STAT_BLANK, 1'b1);
    cmd(20'h00000, 32'h00000025);
    cmd(20'h01FFE, 32'h000000D0);
    stat_bit("blank used", flash_seq_pkg::STAT_BLANK, 1'b0);
    cmd(20'h00000, 32'h00000099);
    stat_bit("bad command", flash_seq_pkg::STAT_SEQ_ERR, 1'b1);
    cmd(20'h03FFE, 32'h00000077);
    cmd(20'h03FFE, 32'h000000FF);
    stat_bit("bad confirm", flash_seq_pkg::STAT_SEQ_ERR, 1'b1);
    lock_read(20'h03FFE, 1'b1);
    cmd(20'h02000, 32'h00000041);
    cmd(20'h02004, 32'h00000011);
    stat_bit("bad target", flash_seq_pkg::STAT_SEQ_ERR, 1'b1);
    check("no stray prog", 32'd2, u_flash_array_model.prog_count_q);
  endtask
  task automatic suspend_resume();
    prog(20'h02008, 32'h0BADF00D);
    apb(1, flash_seq_pkg::IDX_SUSP, 32'h1);
    repeat (30) @(posedge clk);
    check("suspended busy", 32'h1, {31'h0, busy});
    apb(1, flash_seq_pkg::IDX_SUSP, 32'h0);
    repeat (30) @(posedge clk);
    check("resumed done", 32'h0, {31'h0, busy});
    check("resumed count", 32'd3, u_flash_array_model.prog_count_q);
  endtask
  task automatic reset_values();
    apb(0, flash_seq_pkg::IDX_CTRL0, 0);
    check("ctrl0", {24'h0, flash_seq_pkg::CTRL0_RST}, {24'h0, rd[7:0]});
    apb(0, flash_seq_pkg::IDX_OPTSEL, 0);
    check("optsel", {24'h0, flash_seq_pkg::OPTSEL_VAL}, {24'h0, rd[7:0]});
    apb(0, 20'h00300, 0);
    check("unmapped err", 32'h1, {31'h0, err});
  endtask
  task automatic ctrl6_gate();
    apb(1, flash_seq_pkg::IDX_CTRL1, 32'h00);
    apb(1, flash_seq_pkg::IDX_CTRL6, 32'h01);
    apb(0, flash_seq_pkg::IDX_CTRL6, 0);
    check("ctrl6 blocked", 32'h0, {24'h0, rd[7:0]});
    apb(1, flash_seq_pkg::IDX_CTRL1, 32'h02);
    apb(1, flash_seq_pkg::IDX_CTRL6, 32'h01);
    apb(0, flash_seq_pkg::IDX_CTRL6, 0);
    check("ctrl6 open", 32'h1, {31'h0, rd[0]});
  endtask
  task automatic lock_disable();
    apb(1, flash_seq_pkg::IDX_CTRL0, 32'h04);
    apb(0, flash_seq_pkg::IDX_CTRL0, 0);
    check("lock disable", 32'h1, {31'h0, rd[2]});
  endtask
  task automatic wait_select();
    check("one wait rst", 32'h1, {31'h0, one_wait});
    apb(1, flash_seq_pkg::IDX_CTRL1, 32'h82);
    @(posedge clk);
    check("follow wait", 32'h0, {31'h0, one_wait});
    apb(1, flash_seq_pkg::IDX_CTRL1, 32'h02);
    @(posedge clk);
    check("one wait", 32'h1, {31'h0, one_wait});
  endtask
  task automatic report_and_stop();
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    wait_select();
    reset_values();
    lock_disable();
    ctrl6_gate();
    program_word();
    lock_scenario();
    blank_and_bad();
    suspend_resume();
    report_and_stop();
  end
endmodule
